/* rtl/bscc_chain.v */
// Boundary-scan register: cell chain, pin muxing and instruction decode
//
// How it works
// [RULE_01] Boundary register is one serial chain from test data in to out.
// [RULE_02] Every scanned pin adds one 3-bit cell to the chain.
// [RULE_03] Chain length is a per-device parameter, 603 to 1632 bits.
// [RULE_04] Chain tests external connections and captures internal core signals.
// [RULE_05] Capture stage samples core output data, output enable and pad input.
// [RULE_06] Update stage gives pad value and pad enable when test selects it.
// [RULE_07] Shift, capture and update strobes come from the outside TAP controller.
// [RULE_08] Cell mode select is decoded from the instruction register contents.
// [RULE_09] Float signal is high while the high-impedance instruction is active.
// [RULE_10] Serial data passes each cell in to out, test data in to out.
// [RULE_11] User pins capture out, oe, pad; drive pad, pad enable, core input.
// [RULE_12] Dedicated inputs capture 0, 1 and pad; no update stage used.
// [RULE_13] Open-drain config pins capture 0, real enable and pad; no update.
// [RULE_14] Dedicated outputs capture real data, then 0 and 0; no update.
// [RULE_15] Test-port, power and ground pins have no cells in the chain.
// [RULE_16] Code 00 0000 0101 selects chain for sample/preload, non-disturbing.
// [RULE_17] Code 00 0000 1111 selects external test; pins driven from update.
// [RULE_18] Tester changes data in on falling edge; chain samples on rising.
// [RULE_19] Serial out changes on falling edge, high impedance when not shifting.
// [RULE_20] Code 00 0000 1011 uses bypass and tri-states every user pin; here no bypass path exists, TDO stays released.
// [RULE_21] Bus-hold and weak pull-up stay on through highz, clamp, extest.
// [RULE_22] Capture loads in capture, shifts in shift, update loads in update.
// [RULE_23] Instruction register is 10 bits, codes compared on all ten bits.
`timescale 1ns/1ps
`include "bscc_regs.vh"
module bscc_chain #(
  parameter N_UIO  = `BSCC_N_UIO,
  parameter N_DIN  = `BSCC_N_DIN,
  parameter N_ODB  = `BSCC_N_ODB,
  parameter N_DOUT = `BSCC_N_DOUT
) (
  // Clock and reset
  input  wire                  clk_in,
  input  wire                  rst_n_in,
  // Test clock and serial pins
  input  wire                  tck_in,
  input  wire                  tdi_in,
  output wire                  tdo_out,
  output wire                  tdo_oe_out,
  // TAP controller state strobes and instruction
  input  wire                  capture_dr_in,
  input  wire                  shift_dr_in,
  input  wire                  update_dr_in,
  input  wire [`BSCC_IR_W-1:0] ir_in,
  // User I/O pins, core side
  input  wire [N_UIO-1:0]      core_output_data_in,
  input  wire [N_UIO-1:0]      core_output_enable_in,
  output wire [N_UIO-1:0]      core_input_drive_out,
  // User I/O pins, pad side
  input  wire [N_UIO-1:0]      uio_pad_in,
  output wire [N_UIO-1:0]      uio_pad_out,
  output wire [N_UIO-1:0]      uio_pad_oe_out,
  output wire [N_UIO-1:0]      uio_hold_en_out,
  // Dedicated clock and configuration inputs
  input  wire [N_DIN-1:0]      din_pad_in,
  output wire [N_DIN-1:0]      din_core_out,
  // Dedicated open-drain configuration pins
  input  wire [N_ODB-1:0]      odb_core_oe_in,
  input  wire [N_ODB-1:0]      odb_pad_in,
  output wire [N_ODB-1:0]      odb_pad_oe_out,
  output wire [N_ODB-1:0]      odb_core_out,
  // Dedicated outputs
  input  wire [N_DOUT-1:0]     dout_core_data_in,
  output wire [N_DOUT-1:0]     dout_pad_out,
  // Decoded status
  output wire                  scan_float_out,
  output wire                  scan_mode_out
);

  localparam N_CELL = N_UIO + N_DIN + N_ODB + N_DOUT;
  localparam O_DIN  = N_UIO;
  localparam O_ODB  = N_UIO + N_DIN;
  localparam O_DOUT = N_UIO + N_DIN + N_ODB;
  localparam N_TAP  = 5 + `BSCC_IR_W;
  localparam N_PAD  = N_UIO + N_DIN + N_ODB;

  // Everything from the TAP side and from pads is asynchronous here
  wire [N_TAP-1:0]      tap_s;
  wire [N_PAD-1:0]      pad_s;
  wire                  tck_s;
  wire                  tdi_s;
  wire                  cap_s;
  wire                  shf_s;
  wire                  upd_s;
  wire [`BSCC_IR_W-1:0] ir_s;
  wire [N_UIO-1:0]      uio_pad_s;
  wire [N_DIN-1:0]      din_pad_s;
  wire [N_ODB-1:0]      odb_pad_s;

  bscc_sync #(.WIDTH(N_TAP)) u_tap_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .async_in ({tck_in, tdi_in, capture_dr_in, shift_dr_in, update_dr_in, ir_in}),
    .sync_out (tap_s)
  );

  bscc_sync #(.WIDTH(N_PAD)) u_pad_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .async_in ({odb_pad_in, din_pad_in, uio_pad_in}),
    .sync_out (pad_s)
  );

  assign tck_s     = tap_s[N_TAP-1];
  assign tdi_s     = tap_s[N_TAP-2];
  assign cap_s     = tap_s[N_TAP-3];
  assign shf_s     = tap_s[N_TAP-4];
  assign upd_s     = tap_s[N_TAP-5];
  assign ir_s      = tap_s[`BSCC_IR_W-1:0];
  assign uio_pad_s = pad_s[N_UIO-1:0];
  assign din_pad_s = pad_s[O_ODB-1:O_DIN];
  assign odb_pad_s = pad_s[N_PAD-1:O_ODB];

  // Test clock edge detection on the synchronised level
  reg  tck_d_r;
  wire tck_rise;
  wire tck_fall;

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      tck_d_r <= `BSCC_LO;
    end else begin
      tck_d_r <= tck_s;
    end
  end

  assign tck_rise = tck_s & ~tck_d_r;
  assign tck_fall = ~tck_s & tck_d_r;

  // Instruction decode, full-width compare
  wire ir_sample;
  wire ir_extest;
  wire ir_highz;
  wire ir_clamp;
  wire chain_sel;
  wire test_mode;

  assign ir_sample = (ir_s == `BSCC_IR_SAMPLE); // [RULE_16] [RULE_23]
  assign ir_extest = (ir_s == `BSCC_IR_EXTEST); // [RULE_17] [RULE_23]
  assign ir_highz  = (ir_s == `BSCC_IR_HIGHZ);  // [RULE_20] [RULE_23]
  assign ir_clamp  = (ir_s == `BSCC_IR_CLAMP);  // [RULE_23]
  assign chain_sel = ir_sample | ir_extest;
  // Clamp also holds pins from the update stages
  assign test_mode = ir_extest | ir_clamp;      // [RULE_08]

  // Phase tracker, latched from TAP strobes on each edge
  reg [`BSCC_ST_W-1:0] st_r;
  reg [`BSCC_ST_W-1:0] st_nxt;

  always @* begin
    st_nxt = st_r;
    case (st_r)
      `BSCC_ST_IDLE,
      `BSCC_ST_UPD: begin
        if (cap_s) begin
          st_nxt = `BSCC_ST_CAP;
        end else if (shf_s) begin
          st_nxt = `BSCC_ST_SHIFT;
        end else if (upd_s) begin
          st_nxt = `BSCC_ST_UPD;
        end else begin
          st_nxt = `BSCC_ST_IDLE;
        end
      end
      `BSCC_ST_CAP,
      `BSCC_ST_SHIFT: begin
        if (shf_s) begin
          st_nxt = `BSCC_ST_SHIFT;
        end else if (upd_s) begin
          st_nxt = `BSCC_ST_UPD;
        end else if (cap_s) begin
          st_nxt = `BSCC_ST_CAP;
        end else begin
          st_nxt = `BSCC_ST_IDLE;
        end
      end
      default: begin
        st_nxt = `BSCC_ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_r <= `BSCC_ST_IDLE;
    end else if (tck_rise | tck_fall) begin
      st_r <= st_nxt;
    end
  end

  // One-cycle strobes into every cell
  wire cell_cap;
  wire cell_shift;
  wire cell_upd;

  assign cell_cap   = chain_sel & tck_rise & cap_s;   // [RULE_07] [RULE_22]
  assign cell_shift = chain_sel & tck_rise & shf_s;   // [RULE_18] [RULE_22]
  // Update on falling edge so pins change away from capture
  assign cell_upd   = chain_sel & tck_fall & upd_s &
                      (st_r != `BSCC_ST_UPD);        // [RULE_22]

  // Serial chain, cell 0 nearest test data in
  wire [N_CELL:0]  chain_w;
  wire [N_UIO-1:0] upd_out_w;
  wire [N_UIO-1:0] upd_oe_w;
  wire [N_UIO-1:0] upd_in_w;

  assign chain_w[0] = tdi_s; // [RULE_01] [RULE_10]

  genvar gi;
  generate
    for (gi = 0; gi < N_CELL; gi = gi + 1) begin : g_cell
      if (gi < O_DIN) begin : g_uio
        bscc_cell u_cell (
          .clk_in          (clk_in),
          .rst_n_in        (rst_n_in),
          .cap_en_in       (cell_cap),
          .shift_en_in     (cell_shift),
          .upd_en_in       (cell_upd),
          .cell_serial_in  (chain_w[gi]),
          .cell_serial_out (chain_w[gi+1]),
          .cap_out_in      (core_output_data_in[gi]),   // [RULE_05] [RULE_11]
          .cap_oe_in       (core_output_enable_in[gi]), // [RULE_04]
          .cap_pin_in      (uio_pad_s[gi]),
          .upd_out_out     (upd_out_w[gi]),             // [RULE_06]
          .upd_oe_out      (upd_oe_w[gi]),
          .upd_in_out      (upd_in_w[gi])
        ); // [RULE_02]
      end else if (gi < O_ODB) begin : g_din
        bscc_cell u_cell (
          .clk_in          (clk_in),
          .rst_n_in        (rst_n_in),
          .cap_en_in       (cell_cap),
          .shift_en_in     (cell_shift),
          .upd_en_in       (cell_upd),
          .cell_serial_in  (chain_w[gi]),
          .cell_serial_out (chain_w[gi+1]),
          .cap_out_in      (`BSCC_LO),                  // [RULE_12]
          .cap_oe_in       (`BSCC_HI),
          .cap_pin_in      (din_pad_s[gi-O_DIN]),
          .upd_out_out     (),
          .upd_oe_out      (),
          .upd_in_out      ()
        );
      end else if (gi < O_DOUT) begin : g_odb
        bscc_cell u_cell (
          .clk_in          (clk_in),
          .rst_n_in        (rst_n_in),
          .cap_en_in       (cell_cap),
          .shift_en_in     (cell_shift),
          .upd_en_in       (cell_upd),
          .cell_serial_in  (chain_w[gi]),
          .cell_serial_out (chain_w[gi+1]),
          .cap_out_in      (`BSCC_LO),                  // [RULE_13]
          .cap_oe_in       (odb_core_oe_in[gi-O_ODB]),
          .cap_pin_in      (odb_pad_s[gi-O_ODB]),
          .upd_out_out     (),
          .upd_oe_out      (),
          .upd_in_out      ()
        );
      end else begin : g_dout
        bscc_cell u_cell (
          .clk_in          (clk_in),
          .rst_n_in        (rst_n_in),
          .cap_en_in       (cell_cap),
          .shift_en_in     (cell_shift),
          .upd_en_in       (cell_upd),
          .cell_serial_in  (chain_w[gi]),
          .cell_serial_out (chain_w[gi+1]),
          .cap_out_in      (dout_core_data_in[gi-O_DOUT]), // [RULE_14]
          .cap_oe_in       (`BSCC_LO),
          .cap_pin_in      (`BSCC_LO),
          .upd_out_out     (),
          .upd_oe_out      (),
          .upd_in_out      ()
        );
      end
    end
  endgenerate
  // Test-port and supply pins simply have no entry above [RULE_15] [RULE_03]

  // Serial output, launched on the falling edge
  reg tdo_r;
  reg tdo_oe_r;

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      tdo_r    <= `BSCC_LO;
      tdo_oe_r <= `BSCC_LO;
    end else if (tck_fall) begin
      tdo_r    <= chain_w[N_CELL];      // [RULE_19] [RULE_01]
      tdo_oe_r <= chain_sel & shf_s;    // [RULE_19]
    end
  end

  // Pin and core paths, registered so outputs come from flops
  reg [N_UIO-1:0]  uio_pad_r;
  reg [N_UIO-1:0]  uio_oe_r;
  reg [N_UIO-1:0]  core_in_r;
  reg [N_UIO-1:0]  hold_en_r;
  reg [N_DIN-1:0]  din_core_r;
  reg [N_ODB-1:0]  odb_oe_r;
  reg [N_ODB-1:0]  odb_core_r;
  reg [N_DOUT-1:0] dout_pad_r;
  reg              float_r;
  reg              mode_r;

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      uio_pad_r  <= {N_UIO{`BSCC_LO}};
      uio_oe_r   <= {N_UIO{`BSCC_LO}};
      core_in_r  <= {N_UIO{`BSCC_LO}};
      hold_en_r  <= {N_UIO{`BSCC_HI}};
      din_core_r <= {N_DIN{`BSCC_LO}};
      odb_oe_r   <= {N_ODB{`BSCC_LO}};
      odb_core_r <= {N_ODB{`BSCC_LO}};
      dout_pad_r <= {N_DOUT{`BSCC_LO}};
      float_r    <= `BSCC_LO;
      mode_r     <= `BSCC_LO;
    end else begin
      float_r    <= ir_highz;                                      // [RULE_09]
      mode_r     <= test_mode;                                     // [RULE_08]
      uio_pad_r  <= test_mode ? upd_out_w : core_output_data_in;   // [RULE_06] [RULE_17]
      if (ir_highz) begin
        uio_oe_r <= {N_UIO{`BSCC_LO}};                             // [RULE_20]
      end else begin
        uio_oe_r <= test_mode ? upd_oe_w : core_output_enable_in;  // [RULE_16]
      end
      core_in_r  <= test_mode ? upd_in_w : uio_pad_s;              // [RULE_11]
      // Keepers never follow the tri-state, they override it
      hold_en_r  <= {N_UIO{`BSCC_HI}};                             // [RULE_21]
      din_core_r <= din_pad_s;
      odb_oe_r   <= odb_core_oe_in;
      odb_core_r <= odb_pad_s;
      dout_pad_r <= dout_core_data_in;
    end
  end

  assign tdo_out              = tdo_r;
  assign tdo_oe_out           = tdo_oe_r;
  assign uio_pad_out          = uio_pad_r;
  assign uio_pad_oe_out       = uio_oe_r;
  assign core_input_drive_out = core_in_r;
  assign uio_hold_en_out      = hold_en_r;
  assign din_core_out         = din_core_r;
  assign odb_pad_oe_out       = odb_oe_r;
  assign odb_core_out         = odb_core_r;
  assign dout_pad_out         = dout_pad_r;
  assign scan_float_out       = float_r;
  assign scan_mode_out        = mode_r;

endmodule // bscc_chain

/* inc/bscc_regs.vh */
// Constants for the boundary-scan cell chain
`ifndef BSCC_REGS_VH
`define BSCC_REGS_VH

// Instruction register
`define BSCC_IR_W          10
`define BSCC_IR_SAMPLE     10'h005
`define BSCC_IR_EXTEST     10'h00F
`define BSCC_IR_HIGHZ      10'h00B
`define BSCC_IR_CLAMP      10'h00A

// Cell layout, serial order in -> oe -> out
`define BSCC_CELL_W        3
`define BSCC_BIT_IN        0
`define BSCC_BIT_OE        1
`define BSCC_BIT_OUT       2
`define BSCC_CELL_RST      3'h0

// Default pin counts per type, 201 cells = 603 bits
`define BSCC_N_UIO         190
`define BSCC_N_DIN         8
`define BSCC_N_ODB         2
`define BSCC_N_DOUT        1

// Constant capture values
`define BSCC_LO            1'b0
`define BSCC_HI            1'b1

// Data-register phase states, one-hot
`define BSCC_ST_W          4
`define BSCC_ST_IDLE       4'h1
`define BSCC_ST_CAP        4'h2
`define BSCC_ST_SHIFT      4'h4
`define BSCC_ST_UPD        4'h8

`endif

/* rtl/bscc_sync.v */
// Two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module bscc_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             clk_in,
  input  wire             rst_n_in,
  // Levels
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule // bscc_sync

/* rtl/bscc_cell.v */
// One 3-bit boundary-scan cell: capture/shift stage and update stage
`timescale 1ns/1ps
`include "bscc_regs.vh"
module bscc_cell (
  // Clock and reset
  input  wire clk_in,
  input  wire rst_n_in,
  // Strobes from the chain control
  input  wire cap_en_in,
  input  wire shift_en_in,
  input  wire upd_en_in,
  // Serial path
  input  wire cell_serial_in,
  output wire cell_serial_out,
  // Capture sources
  input  wire cap_out_in,
  input  wire cap_oe_in,
  input  wire cap_pin_in,
  // Update stage
  output wire upd_out_out,
  output wire upd_oe_out,
  output wire upd_in_out
);

  reg [`BSCC_CELL_W-1:0] cap_r;
  reg [`BSCC_CELL_W-1:0] upd_r;

  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      cap_r <= `BSCC_CELL_RST;
    end else if (cap_en_in) begin
      cap_r[`BSCC_BIT_OUT] <= cap_out_in;
      cap_r[`BSCC_BIT_OE]  <= cap_oe_in;
      cap_r[`BSCC_BIT_IN]  <= cap_pin_in;
    end else if (shift_en_in) begin
      cap_r <= {cap_r[`BSCC_CELL_W-2:0], cell_serial_in};
    end
  end

  // Update stage holds while the capture stage shifts
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      upd_r <= `BSCC_CELL_RST;
    end else if (upd_en_in) begin
      upd_r <= cap_r;
    end
  end

  assign cell_serial_out = cap_r[`BSCC_BIT_OUT];
  assign upd_out_out     = upd_r[`BSCC_BIT_OUT];
  assign upd_oe_out      = upd_r[`BSCC_BIT_OE];
  assign upd_in_out      = upd_r[`BSCC_BIT_IN];

endmodule // bscc_cell

/* dv/bscc_chain_assertions.sv */
// Port-level checker for the boundary-scan chain
`timescale 1ns/1ps
`include "bscc_regs.vh"
module bscc_chain_assertions #(
  parameter N_UIO  = 2,
  parameter N_DIN  = 1,
  parameter N_ODB  = 1,
  parameter N_DOUT = 1
) (
  // Clock, reset and TAP levels
  input logic                  clk_in,
  input logic                  rst_n_in,
  input logic                  shift_dr_in,
  input logic                  update_dr_in,
  input logic [`BSCC_IR_W-1:0] ir_in,
  input logic                  tdo_oe_out,
  // User pins
  input logic [N_UIO-1:0]      core_output_data_in,
  input logic [N_UIO-1:0]      core_output_enable_in,
  input logic [N_UIO-1:0]      uio_pad_out,
  input logic [N_UIO-1:0]      uio_pad_oe_out,
  input logic [N_UIO-1:0]      uio_hold_en_out,
  // Dedicated pins
  input logic [N_DIN-1:0]      din_pad_in,
  input logic [N_DIN-1:0]      din_core_out,
  input logic [N_ODB-1:0]      odb_core_oe_in,
  input logic [N_ODB-1:0]      odb_pad_in,
  input logic [N_ODB-1:0]      odb_pad_oe_out,
  input logic [N_ODB-1:0]      odb_core_out,
  input logic [N_DOUT-1:0]     dout_core_data_in,
  input logic [N_DOUT-1:0]     dout_pad_out,
  // Decode status
  input logic                  scan_float_out,
  input logic                  scan_mode_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // Instruction held long enough to pass the synchronisers
  sequence ir_steady;
    (rst_n_in && $stable(ir_in)) [*6];
  endsequence

  float_dec_a: assert property (ir_steady |-> scan_float_out == (ir_in == `BSCC_IR_HIGHZ))
    else $error("float flag does not follow instruction");
  mode_dec_a: assert property (ir_steady |->
    scan_mode_out == (ir_in == `BSCC_IR_EXTEST || ir_in == `BSCC_IR_CLAMP))
    else $error("mode select does not follow instruction");
  highz_oe_a: assert property (ir_steady ##0 ir_in == `BSCC_IR_HIGHZ |-> uio_pad_oe_out == '0)
    else $error("user pin enabled under float instruction");
  func_path_a: assert property (ir_steady ##0 (ir_in != `BSCC_IR_EXTEST && ir_in != `BSCC_IR_CLAMP
    && ir_in != `BSCC_IR_HIGHZ) |-> uio_pad_out == $past(core_output_data_in)
    && uio_pad_oe_out == $past(core_output_enable_in))
    else $error("functional path disturbed");
  tdo_idle_a: assert property (!shift_dr_in [*8] |=> ##2 !tdo_oe_out)
    else $error("serial out driven outside shift");
  tdo_refuse_a: assert property (ir_steady ##0 (ir_in != `BSCC_IR_SAMPLE && ir_in != `BSCC_IR_EXTEST)
    |-> !tdo_oe_out)
    else $error("serial out driven for unselected chain");
  hold_on_a: assert property (uio_hold_en_out == '1)
    else $error("keeper disabled");
  ded_pass_a: assert property (rst_n_in [*3] |-> dout_pad_out == $past(dout_core_data_in)
    && odb_pad_oe_out == $past(odb_core_oe_in))
    else $error("dedicated output path wrong");
  pad_in_a: assert property ((rst_n_in && $stable({din_pad_in, odb_pad_in})) [*5] |->
    din_core_out == din_pad_in && odb_core_out == odb_pad_in)
    else $error("dedicated input path wrong");
  upd_hold_a: assert property ((rst_n_in && scan_mode_out && !update_dr_in && $stable(ir_in)) [*8]
    |-> $stable(uio_pad_out))
    else $error("pin changed without update");
endmodule // bscc_chain_assertions

/* dv/bscc_tester.sv */
// External test controller: makes TCK, TDI and the TAP state levels
`timescale 1ns/1ps
module bscc_tester #(
  parameter NB = 15
) (
  // Serial pins
  output logic tck_out,
  output logic tdi_out,
  input  logic tdo_in,
  input  logic tdo_oe_in,
  // TAP state levels
  output logic capture_dr_out,
  output logic shift_dr_out,
  output logic update_dr_out
);
  // TCK parked low and TDI pulled high between frames
  initial begin
    tck_out = 1'b0;
    tdi_out = 1'b1;
    {capture_dr_out, shift_dr_out, update_dr_out} = 3'b000;
  end

  // One TCK period; next state set 50 ns after the rise, as a TAP would
  task automatic step(input logic din, input logic [2:0] nxt);
    tck_out = 1'b0;
    tdi_out = din;
    #200;
    tck_out = 1'b1;
    #50;
    {capture_dr_out, shift_dr_out, update_dr_out} = nxt;
    #150;
  endtask

  // Capture, NB shifts, exit, update; TDO read at the end of the high half
  task automatic scan(input logic [NB-1:0] din, output logic [NB-1:0] dout, output logic [NB-1:0] oes);
    integer i;
    #13;
    {capture_dr_out, shift_dr_out, update_dr_out} = 3'b100;
    #200;
    tck_out = 1'b1;
    #50;
    {capture_dr_out, shift_dr_out, update_dr_out} = 3'b010;
    #150;
    for (i = 0; i < NB; i++) begin
      step(din[i], (i == NB - 1) ? 3'b000 : 3'b010);
      // Undriven TDO has no pull, so a released pin reads as the inverse
      dout[i] = tdo_oe_in ? tdo_in : ~tdo_in;
      oes[i] = tdo_oe_in;
    end
    step(1'b1, 3'b001);
    step(1'b1, 3'b000);
    tck_out = 1'b0;
  endtask
endmodule // bscc_tester

/* dv/tb_top.sv */
// Self-checking bench for the boundary-scan chain
`timescale 1ns/1ps
`include "bscc_regs.vh"
module tb_top;
  typedef struct packed {
    logic [9:0]  ir;
    logic [14:0] pat;
    logic [9:0]  pins;
  } bscc_row_t;
  // Pins: dout data, odb pad, odb oe, din pad, uio pad[2], uio oe[2], uio data[2]
  localparam bscc_row_t ROWS [9] = '{
    '{`BSCC_IR_SAMPLE, 15'h5A3C, 10'h2A5}, '{`BSCC_IR_CLAMP, 15'h7FFF, 10'h15A},
    '{`BSCC_IR_EXTEST, 15'h1E69, 10'h3C3}, '{`BSCC_IR_HIGHZ, 15'h0000, 10'h0FF},
    '{10'h3FF, 15'h7FFF, 10'h300}, '{10'h205, 15'h2AAA, 10'h1D2}, '{10'h00E, 15'h5555, 10'h0F0},
    '{`BSCC_IR_EXTEST, 15'h6B52, 10'h24B}, '{`BSCC_IR_SAMPLE, 15'h0000, 10'h3FF}};
  logic clk_in, rst_n_in, tck_in, tdi_in, tdo_out, tdo_oe_out;
  logic capture_dr_in, shift_dr_in, update_dr_in, scan_float_out, scan_mode_out;
  logic [9:0] ir_in;
  logic [1:0] core_output_data_in, core_output_enable_in, core_input_drive_out;
  logic [1:0] uio_pad_in, uio_pad_out, uio_pad_oe_out, uio_hold_en_out;
  logic din_pad_in, din_core_out, odb_core_oe_in, odb_pad_in, odb_pad_oe_out, odb_core_out;
  logic dout_core_data_in, dout_pad_out;
  logic [14:0] got, oes, u;
  int fails, samples_checked;

  bscc_chain #(.N_UIO(2), .N_DIN(1), .N_ODB(1), .N_DOUT(1)) i_bscc_chain (.*);
  bscc_tester #(.NB(15)) i_bscc_tester (.tck_out(tck_in), .tdi_out(tdi_in), .tdo_in(tdo_out),
    .tdo_oe_in(tdo_oe_out), .capture_dr_out(capture_dr_in), .shift_dr_out(shift_dr_in),
    .update_dr_out(update_dr_in));

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task conclude;
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task check_rst;
    @(negedge clk_in);
    check({tdo_oe_out, scan_mode_out, scan_float_out}, 3'h0);
    check({uio_pad_oe_out, uio_pad_out, core_input_drive_out}, 6'h00);
    check(uio_hold_en_out, 2'b11);
  endtask

  task automatic run_row(input bscc_row_t r);
    logic sel, md, hz;
    logic [14:0] c;
    sel = r.ir == `BSCC_IR_SAMPLE || r.ir == `BSCC_IR_EXTEST;
    md = r.ir == `BSCC_IR_EXTEST || r.ir == `BSCC_IR_CLAMP;
    hz = r.ir == `BSCC_IR_HIGHZ;
    // Capture image, tdi side first: uio0, uio1, din, odb, dout
    c = {r.pins[9], 2'b00, 1'b0, r.pins[7], r.pins[8], 2'b01, r.pins[6],
      r.pins[1], r.pins[3], r.pins[5], r.pins[0], r.pins[2], r.pins[4]};
    c = {<<{c}}; // Tdo side leaves first
    @(posedge clk_in);
    ir_in <= r.ir;
    {dout_core_data_in, odb_pad_in, odb_core_oe_in, din_pad_in, uio_pad_in,
      core_output_enable_in, core_output_data_in} <= r.pins;
    repeat (8) @(posedge clk_in);
    i_bscc_tester.scan(r.pat, got, oes);
    check(oes, sel ? 15'h7FFF : 15'h0000);
    if (sel) check(got, c);
    if (sel) u = {<<{r.pat}};
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    check({uio_pad_out, uio_pad_oe_out, core_input_drive_out}, md ? {u[5], u[2], u[4], u[1], u[3], u[0]}
      : {r.pins[1:0], hz ? 2'b00 : r.pins[3:2], r.pins[5:4]});
    check({scan_mode_out, scan_float_out, din_core_out, odb_core_out, odb_pad_oe_out, dout_pad_out},
      {md, hz, r.pins[6], r.pins[8], r.pins[7], r.pins[9]});
  endtask

  initial begin
    rst_n_in = 1'b0;
    ir_in = 10'h000;
    u = 15'h0000;
    {dout_core_data_in, odb_pad_in, odb_core_oe_in, din_pad_in, uio_pad_in,
      core_output_enable_in, core_output_data_in} = 10'h000;
    repeat (11) @(posedge clk_in);
    check_rst;
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    foreach (ROWS[i]) run_row(ROWS[i]);
    // Reset in mid-run under clamp: update stages must come back cleared
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    ir_in <= `BSCC_IR_CLAMP;
    repeat (4) @(posedge clk_in);
    check_rst;
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    @(negedge clk_in);
    check({uio_pad_out, uio_pad_oe_out, core_input_drive_out, scan_mode_out}, 7'h01);
    conclude;
  end

  // Nine scans of about 20 TCK periods each fit well inside this span
  initial begin
    #400000;
    fails++;
    conclude;
  end
endmodule // tb_top

bind bscc_chain bscc_chain_assertions #(.N_UIO(N_UIO), .N_DIN(N_DIN), .N_ODB(N_ODB), .N_DOUT(N_DOUT))
  i_bscc_chain_assertions (.*);
